// ==== hwd_pkg.sv ====
// hwd_pkg: constants and types for the hardware watchdog with reset-out
// assumes: one oscillator clock, sfr writes presented as one-cycle strobes
package hwd_pkg;
	localparam logic [7:0]  HWD_RESTART_ADDR = 8'ha6;
	localparam logic [7:0]  HWD_KEY_FIRST    = 8'h1e;
	localparam logic [7:0]  HWD_KEY_SECOND   = 8'he1;
	localparam int          HWD_CNT_W        = 14;
	localparam logic [13:0] HWD_CNT_LIMIT    = 14'h3fff;
	localparam logic [13:0] HWD_CNT_RESET    = 14'h0000;
	localparam int          HWD_MC_FAST      = 6;
	localparam int          HWD_MC_SLOW      = 12;
	localparam int          HWD_PULSE_FAST   = 98;
	localparam int          HWD_PULSE_SLOW   = 196;
	localparam int          HWD_PULSE_W      = 8;
	localparam int          HWD_MC_W         = 4;

	typedef enum logic [1:0] {
		HWD_IDLE  = 2'b00,
		HWD_KEYED = 2'b01
	} hwd_seq_e;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} hwd_sfr_wr_s;
endpackage

// ==== hwd_mc_tick.sv ====
// hwd_mc_tick: machine-cycle enable from the oscillator clock
// assumes: mode select is static between resets
`timescale 1ns/1ps
module hwd_mc_tick
	import hwd_pkg::*;
#(
	// divider sizing
	parameter int MC_W    = HWD_MC_W,
	parameter int MC_FAST = HWD_MC_FAST,
	parameter int MC_SLOW = HWD_MC_SLOW
)
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// mode and tick
	input  wire logic mode_12clk,
	output logic      mc_tick
);
	logic [MC_W-1:0] div_reg;
	logic [MC_W-1:0] div_next;
	wire  [MC_W-1:0] div_last = mode_12clk ? MC_W'(MC_SLOW - 1)
	                                       : MC_W'(MC_FAST - 1);
	wire                 wrap     = (div_reg >= div_last);

	assign div_next = wrap ? '0 : div_reg + 1'b1;
	assign mc_tick  = wrap;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end
endmodule

// ==== hwd_watchdog.sv ====
// hwd_watchdog: one-time-enabled watchdog with restart key and reset-out pulse
// assumes: cpu sfr writes arrive as one-cycle strobes on core_clk; reads of the
// restart address are answered elsewhere with no watchdog state.
// Operation
// - watchdog timing comes only from a 14-bit counter
// - after any reset the watchdog is off and does not count
// - writing 1e then e1 to address a6 arms the watchdog
// - armed counter advances once each machine cycle
// - once armed only reset or overflow disarms it
// - each completed 1e,e1 pair clears the counter while armed
// - reaching 3fff is overflow and resets the whole device
// - overflow drives high reset pulse: 98 or 196 oscillator periods
// - restart register is write only, reads expose nothing
// - counter cannot be read or loaded by software
`timescale 1ns/1ps
module hwd_watchdog
	import hwd_pkg::*;
#(
	// counter sizing
	parameter int               CNT_W      = HWD_CNT_W,
	parameter logic [CNT_W-1:0] CNT_LIMIT  = CNT_W'(HWD_CNT_LIMIT),
	// machine-cycle length in oscillator clocks
	parameter int               MC_FAST    = HWD_MC_FAST,
	parameter int               MC_SLOW    = HWD_MC_SLOW,
	// reset-out pulse length in oscillator clocks
	parameter int               PULSE_W    = HWD_PULSE_W,
	parameter int               PULSE_FAST = HWD_PULSE_FAST,
	parameter int               PULSE_SLOW = HWD_PULSE_SLOW
)
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// configuration
	input  wire logic        mode_12clk,
	// sfr write port
	input  wire hwd_sfr_wr_s sfr_wr,
	// status and reset-out
	output logic             wd_armed,
	output logic             wd_reset_req,
	output logic             rst_pin_out,
	output logic             rst_pin_oe
);
	// key sequence and arming
	hwd_seq_e           seq_reg;
	hwd_seq_e           seq_next;
	logic               armed_reg;
	logic               armed_next;
	// timing elements
	logic [CNT_W-1:0]   cnt_reg;
	logic [CNT_W-1:0]   cnt_next;
	logic [PULSE_W-1:0] pulse_reg;
	logic [PULSE_W-1:0] pulse_next;
	// registered outputs and tick
	logic               req_reg;
	logic               req_next;
	logic               pin_reg;
	logic               pin_next;
	logic               mc_tick;

	// a write strobe aimed at the restart register
	function automatic logic f_restart_hit(input hwd_sfr_wr_s wr);
		return wr.wr && (wr.addr == HWD_RESTART_ADDR);
	endfunction

	// a restart write carrying the given key byte
	function automatic logic f_key_is(input hwd_sfr_wr_s wr, input logic [7:0] key);
		return f_restart_hit(wr) && (wr.data == key);
	endfunction

	// pulse timer still running
	function automatic logic f_pulse_active(input logic [PULSE_W-1:0] count);
		return count != '0;
	endfunction

	// pulse length for the selected machine-cycle mode
	function automatic logic [PULSE_W-1:0] f_pulse_len(input logic slow);
		return slow ? PULSE_W'(PULSE_SLOW) : PULSE_W'(PULSE_FAST);
	endfunction

	// key state after one restart write; a repeated first key re-keys
	function automatic hwd_seq_e f_seq_step(input hwd_seq_e state, input logic [7:0] data);
		hwd_seq_e step;
		step = HWD_IDLE;
		unique case (state)
			HWD_IDLE: begin
				if (data == HWD_KEY_FIRST) begin
					step = HWD_KEYED;
				end else begin
					step = HWD_IDLE;
				end
			end
			HWD_KEYED: begin
				if (data == HWD_KEY_FIRST) begin
					step = HWD_KEYED;
				end else begin
					step = HWD_IDLE;
				end
			end
			default: begin
				step = HWD_IDLE;
			end
		endcase
		return step;
	endfunction

	// counter step: held clear while off, on service and on overflow
	function automatic logic [CNT_W-1:0] f_cnt_step(input logic [CNT_W-1:0] count,
	                                                input logic             clear,
	                                                input logic             tick);
		logic [CNT_W-1:0] step;
		step = count;
		if (clear) begin
			step = CNT_W'(HWD_CNT_RESET);
		end else if (tick) begin
			step = count + 1'b1;
		end
		return step;
	endfunction

	// divider runs from reset, so the first tick after a service lands within one machine cycle (6 or 12 clocks)
	hwd_mc_tick #(
		.MC_W    (HWD_MC_W),
		.MC_FAST (MC_FAST),
		.MC_SLOW (MC_SLOW)
	) u_tick (
		.core_clk   (core_clk),
		.reset      (reset),
		.mode_12clk (mode_12clk),
		.mc_tick    (mc_tick)
	);

	// only writes are decoded; nothing here drives read data
	wire               hit       = f_restart_hit(sfr_wr);
	wire               key_done  = f_key_is(sfr_wr, HWD_KEY_SECOND) && (seq_reg == HWD_KEYED);
	wire               overflow  = armed_reg && (cnt_reg == CNT_LIMIT);
	wire               cnt_clear = !armed_reg || key_done || overflow;
	wire               pulse_on  = f_pulse_active(pulse_reg);
	wire [PULSE_W-1:0] pulse_len = f_pulse_len(mode_12clk);

	// writes to other addresses leave a pending first key alone
	assign seq_next   = hit ? f_seq_step(seq_reg, sfr_wr.data) : seq_reg;
	// no path clears the armed flag except reset and overflow
	assign armed_next = (armed_reg || key_done) && !overflow;
	// a pair landing on the overflow cycle loses: the device is going down anyway
	assign req_next   = overflow;
	assign cnt_next   = f_cnt_step(cnt_reg, cnt_clear, mc_tick);

	// pulse counted in oscillator clocks, not machine cycles
	always_comb begin
		pulse_next = pulse_reg;
		if (overflow) begin
			pulse_next = pulse_len;
		end else if (pulse_on) begin
			pulse_next = pulse_reg - 1'b1;
		end
	end

	// pin level taken from the next count so it rises with the request
	assign pin_next = f_pulse_active(pulse_next);

	// key state
	always_ff @(posedge core_clk) begin
		if (reset) begin
			seq_reg <= HWD_IDLE;
		end else begin
			seq_reg <= seq_next;
		end
	end

	// arming flag: off after any reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			armed_reg <= 1'b0;
		end else begin
			armed_reg <= armed_next;
		end
	end

	// watchdog counter
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_reg <= CNT_W'(HWD_CNT_RESET);
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// pulse timer
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pulse_reg <= '0;
		end else begin
			pulse_reg <= pulse_next;
		end
	end

	// one-cycle device reset request
	always_ff @(posedge core_clk) begin
		if (reset) begin
			req_reg <= 1'b0;
		end else begin
			req_reg <= req_next;
		end
	end

	// pin drive level
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin_reg <= 1'b0;
		end else begin
			pin_reg <= pin_next;
		end
	end

	// a sync reset mid-pulse cuts it short, so the pin must not be looped
	// straight back to this block's reset input
	assign wd_armed     = armed_reg;
	assign wd_reset_req = req_reg;
	assign rst_pin_out  = pin_reg;
	assign rst_pin_oe   = pin_reg;
endmodule

// ==== hwd_chk.sv ====
// hwd_chk: port assertions for hwd_watchdog
// assumes: bound to every hwd_watchdog instance
`timescale 1ns/1ps
module hwd_chk
	import hwd_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        mode_12clk,
	input wire hwd_sfr_wr_s sfr_wr,
	input wire logic        wd_armed,
	input wire logic        wd_reset_req,
	input wire logic        rst_pin_out,
	input wire logic        rst_pin_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	wire at_reg = sfr_wr.wr && sfr_wr.addr == HWD_RESTART_ADDR;
	sequence s_pair;
		(at_reg && sfr_wr.data == HWD_KEY_FIRST) ##1 (at_reg && sfr_wr.data == HWD_KEY_SECOND);
	endsequence
	a_oe_same: assert property (rst_pin_oe == rst_pin_out)
		else $error("pin enable differs from level");
	a_pair_arms: assert property (s_pair |=> wd_armed || wd_reset_req)
		else $error("key pair did not arm");
	a_arm_cause: assert property ($rose(wd_armed) |-> $past(at_reg && sfr_wr.data == HWD_KEY_SECOND))
		else $error("armed without key");
	a_stays_armed: assert property (wd_armed |=> wd_armed || wd_reset_req)
		else $error("disarmed without overflow");
	a_req_cause: assert property (wd_reset_req |-> $past(wd_armed) && !wd_armed && rst_pin_out)
		else $error("bad overflow request");
	a_req_single: assert property (wd_reset_req |=> !wd_reset_req)
		else $error("request too long");
	a_pin_cause: assert property ($rose(rst_pin_out) |-> wd_reset_req)
		else $error("pin pulse without overflow");
	a_pulse_fast: assert property ($rose(rst_pin_out) && !mode_12clk |-> (rst_pin_out throughout (##97 1'b1)) ##1 !rst_pin_out)
		else $error("fast pulse length wrong");
endmodule
bind hwd_watchdog hwd_chk u_chk (
	.core_clk     (core_clk),
	.reset        (reset),
	.mode_12clk   (mode_12clk),
	.sfr_wr       (sfr_wr),
	.wd_armed     (wd_armed),
	.wd_reset_req (wd_reset_req),
	.rst_pin_out  (rst_pin_out),
	.rst_pin_oe   (rst_pin_oe)
);

// ==== test_hardware_watchdog_reset_out.sv ====
// test_hardware_watchdog_reset_out: directed tests of hwd_watchdog
// assumes: hwd_chk bound; 6-clock mode only, 12-clock overflow is too long to run
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
	$display("Error %0t: got %0h expected %0h", $time, (got), (exp)); end end
module test_hardware_watchdog_reset_out
	import hwd_pkg::*;
;
	logic        core_clk = 0, reset = 1, mode_12clk = 0;
	hwd_sfr_wr_s sfr_wr = '0;
	logic        wd_armed, wd_reset_req, rst_pin_out, rst_pin_oe;
	int          error_cnt = 0, comparisons = 0, n;
	always #2.5 core_clk = ~core_clk;
	hwd_watchdog DUT (.core_clk(core_clk), .reset(reset), .mode_12clk(mode_12clk), .sfr_wr(sfr_wr),
		.wd_armed(wd_armed), .wd_reset_req(wd_reset_req), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe));
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk) sfr_wr = {1'b1, a, d};
	endtask
	task idle(input int c);
		@(negedge core_clk) sfr_wr.wr = 1'b0;
		repeat (c) @(negedge core_clk);
	endtask
	task test_done;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// wrong address, then a broken pair: neither may arm
	task t_refuse;
		`CHK(wd_armed, 1'b0)
		wr(8'ha7, HWD_KEY_FIRST);
		wr(8'ha7, HWD_KEY_SECOND);
		wr(HWD_RESTART_ADDR, HWD_KEY_FIRST);
		wr(HWD_RESTART_ADDR, 8'h55);
		wr(HWD_RESTART_ADDR, HWD_KEY_SECOND);
		idle(60);
		`CHK(wd_armed, 1'b0)
		`CHK(wd_reset_req, 1'b0)
		`CHK(rst_pin_oe, 1'b0)
		$display("refuse test done");
	endtask
	// a service some 600 cycles after arming must push overflow a full period past it
	task t_overflow;
		wr(HWD_RESTART_ADDR, HWD_KEY_FIRST);
		wr(HWD_RESTART_ADDR, HWD_KEY_SECOND);
		idle(1);
		`CHK(wd_armed, 1'b1)
		idle(600);
		wr(HWD_RESTART_ADDR, HWD_KEY_FIRST);
		wr(HWD_RESTART_ADDR, HWD_KEY_SECOND);
		idle(0);
		for (n = 1; wd_reset_req !== 1'b1 && n < 99000; n++) @(negedge core_clk);
		`CHK(n >= 98295 && n <= 98300, 1'b1)
		`CHK(wd_armed, 1'b0)
		`CHK(rst_pin_oe, 1'b1)
		for (n = 0; rst_pin_out === 1'b1 && n < 300; n++) @(negedge core_clk);
		`CHK(n, HWD_PULSE_FAST)
		`CHK(rst_pin_oe, 1'b0)
		$display("overflow test done");
	endtask
	// a reset in mid-run must leave an armed watchdog off
	task t_reset_armed;
		wr(HWD_RESTART_ADDR, HWD_KEY_FIRST);
		wr(HWD_RESTART_ADDR, HWD_KEY_SECOND);
		idle(1);
		`CHK(wd_armed, 1'b1)
		reset = 1'b1;
		@(negedge core_clk) reset = 1'b0;
		idle(2);
		`CHK(wd_armed, 1'b0)
		`CHK(rst_pin_out, 1'b0)
		$display("reset test done");
	endtask
	initial begin
		repeat (10) @(negedge core_clk);
		reset = 0;
		t_refuse;
		t_reset_armed;
		t_overflow;
		test_done;
	end
	initial begin
		repeat (99600) @(posedge core_clk);
		error_cnt++;
		test_done;
	end
endmodule
